// ==== rtl/csd_chip_select.sv ====
// Chip-select range decoder with AHB-Lite registers, wait-state sequencing and port pin routing.
// How it works
// - Four select outputs, each with its own programmable address region.
// - A select asserts when the core or DMA unit addresses its region.
// - Selects reach the port pins only when direction and function bits route them.
// - Three access control registers: enable, width, wait count, dummy count.
// - The external wait input stretches the current cycle while it stays asserted.
// - Regions 0 and 1 share one control register, regions 2 and 3 another.
// - The address is compared afresh on every bus cycle.
// - The base field gives A31-A16; the low sixteen bits are zero.
// - A set mask bit drops that address bit from the comparison.
// - Masks act on A29-A14 for regions 0-1 and A30-A15 for 2-3.
// - Region size follows from the bits below the mask range and the bits the mask excludes.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module csd_chip_select #(
    parameter int WAIT_W = 3
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Processor core request.
    input wire logic core_req,
    input wire logic [31:0] core_addr,
    input wire logic core_write,
    output logic core_done,
    // Internal DMA unit request.
    input wire logic dma_req,
    input wire logic [31:0] dma_addr,
    input wire logic dma_write,
    output logic dma_done,
    // External memory side.
    input wire logic ext_wait_n,
    output logic [3:0] region_select_n,
    output logic bus_wide,
    output logic [3:0] shared_port_pins_out,
    output logic [3:0] shared_port_pins_oe
);

    localparam int R = csd_pkg::REGIONS;

    // Register file.
    logic [31:0] region_base_mask_reg [R];
    logic [csd_pkg::CTRL_W-1:0] access_ctrl_q [csd_pkg::CTRL_REGS];
    logic [3:0] port_four_direction_ctrl_q;
    logic [3:0] port_four_function_ctrl_q;

    // Bus slave state.
    logic wr_pend_q;
    logic rd_pend_q;
    logic [31:0] bus_addr_q;
    logic hready_q;
    logic [31:0] hrdata_q;
    logic hresp_q;
    logic [31:0] rdata_d;

    // Bus cycle sequencer state.
    csd_pkg::csd_state_t state_q;
    logic [3:0] cnt_q;
    logic [1:0] dummy_q;
    logic was_read_q;
    logic from_dma_q;
    logic [3:0] sel_n_q;
    logic wide_q;
    logic core_done_q;
    logic dma_done_q;
    logic [3:0] pin_out_q;
    logic [3:0] pin_oe_q;

    // Wait input synchroniser; the first stage feeds only the second.
    logic wait_meta_q;
    logic wait_sync_q;

    // Decode signals.
    logic [31:0] req_addr;
    logic req_any;
    logic req_write;
    logic [R-1:0] region_en;
    logic [R-1:0] hit;
    logic [R-1:0] sel_d;
    logic [csd_pkg::CTRL_W-1:0] ctrl_sel;
    logic [WAIT_W-1:0] wait_cnt;
    logic addr_phase;
    logic take;

    assign addr_phase = hsel && htrans[1] && hready;

    // The core has priority over the DMA unit when both request together.
    assign req_any = core_req || dma_req;
    assign req_addr = core_req ? core_addr : dma_addr;
    assign req_write = core_req ? core_write : dma_write;
    // A requester sees done a cycle late, so a request standing beside the done pulse is not taken again.
    assign take = (state_q == csd_pkg::ST_IDLE) && req_any && !core_done_q && !dma_done_q;

    // Per-region base/mask comparison.
    for (genvar g = 0; g < R; g++) begin : g_region
        logic [31:0] base_w;
        logic [31:0] mask_w;
        logic [31:0] cmp_w;
        // Lower sixteen bits of the start are zero.
        assign base_w = {region_base_mask_reg[g][csd_pkg::BASE_MSB:csd_pkg::BASE_LSB], 16'h0000};
        // The mask field is placed on the region's own address bit range.
        assign mask_w = {16'h0000, region_base_mask_reg[g][csd_pkg::MASK_MSB:0]} << csd_pkg::REGION_SHIFT[g];
        // Bits under the mask range and masked bits take no part; that alone sets the size.
        assign cmp_w = ~mask_w & ~csd_pkg::REGION_LOW_BITS[g];
        // Pair g/2 shares one control register.
        assign region_en[g] = access_ctrl_q[g / 2][csd_pkg::CTRL_EN_BIT];
        // Compared on the live request address, never a held result.
        assign hit[g] = region_en[g] && (((req_addr ^ base_w) & cmp_w) == 32'h00000000);
    end

    // Lowest-numbered enabled match wins.
    always_comb begin
        sel_d = '0;
        for (int i = R - 1; i >= 0; i--) begin
            if (hit[i]) begin
                sel_d = '0;
                sel_d[i] = 1'b1;
            end
        end
    end

    // Timing options come from the pair register of the winner, else the other-space register.
    always_comb begin
        if (|sel_d[1:0]) begin
            ctrl_sel = access_ctrl_q[csd_pkg::CTRL_LOW_PAIR];
        end else if (|sel_d[3:2]) begin
            ctrl_sel = access_ctrl_q[csd_pkg::CTRL_HIGH_PAIR];
        end else begin
            ctrl_sel = access_ctrl_q[csd_pkg::CTRL_OTHER];
        end
    end

    assign wait_cnt = ctrl_sel[csd_pkg::CTRL_WAIT_MSB:csd_pkg::CTRL_WAIT_LSB];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_meta_q <= 1'b0;
            wait_sync_q <= 1'b0;
        end else begin
            wait_meta_q <= ~ext_wait_n;
            wait_sync_q <= wait_meta_q;
        end
    end

    // Bus cycle sequencer: basic cycle plus programmed waits, stretched by the wait input.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= csd_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            dummy_q <= 2'h0;
            was_read_q <= 1'b0;
            from_dma_q <= 1'b0;
            sel_n_q <= 4'hf;
            wide_q <= 1'b0;
            core_done_q <= 1'b0;
            dma_done_q <= 1'b0;
        end else begin
            core_done_q <= 1'b0;
            dma_done_q <= 1'b0;
            case (state_q)
                csd_pkg::ST_IDLE: begin
                    if (take) begin
                        state_q <= csd_pkg::ST_ACCESS;
                        cnt_q <= csd_pkg::BASE_CYCLES - 4'h1 + 4'(wait_cnt);
                        dummy_q <= ctrl_sel[csd_pkg::CTRL_DUMMY_MSB:csd_pkg::CTRL_DUMMY_LSB];
                        was_read_q <= !req_write;
                        from_dma_q <= !core_req;
                        sel_n_q <= ~sel_d;
                        wide_q <= ctrl_sel[csd_pkg::CTRL_WIDE_BIT];
                    end
                end
                csd_pkg::ST_ACCESS: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (!wait_sync_q) begin
                        // Held here while the wait input is asserted.
                        sel_n_q <= 4'hf;
                        core_done_q <= !from_dma_q;
                        dma_done_q <= from_dma_q;
                        if (was_read_q && dummy_q != 2'h0) begin
                            // Recovery time only follows a read cycle.
                            state_q <= csd_pkg::ST_DUMMY;
                            cnt_q <= (dummy_q == 2'h1) ? 4'h0 : 4'h1;
                        end else begin
                            state_q <= csd_pkg::ST_IDLE;
                        end
                    end
                end
                csd_pkg::ST_DUMMY: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else begin
                        state_q <= csd_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= csd_pkg::ST_IDLE;
                    sel_n_q <= 4'hf;
                end
            endcase
        end
    end

    // A select reaches its pin only when the port is routed to the select function.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_out_q <= 4'hf;
            pin_oe_q <= 4'h0;
        end else begin
            pin_oe_q <= port_four_direction_ctrl_q & port_four_function_ctrl_q;
            pin_out_q <= ~(port_four_direction_ctrl_q & port_four_function_ctrl_q) | sel_n_q;
        end
    end

    // AHB-Lite slave: writes take no wait, reads take one so the data comes from a flop.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            bus_addr_q <= 32'h00000000;
            hready_q <= 1'b1;
            hrdata_q <= 32'h00000000;
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
            if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                hready_q <= 1'b1;
                hrdata_q <= rdata_d;
            end else if (addr_phase) begin
                bus_addr_q <= haddr;
                wr_pend_q <= hwrite && (hsize == csd_pkg::HSIZE_WORD);
                rd_pend_q <= !hwrite;
                hready_q <= hwrite;
            end else if (hready) begin
                wr_pend_q <= 1'b0;
            end
        end
    end

    // Register writes land at the end of the data phase.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < R; i++) begin
                region_base_mask_reg[i] <= csd_pkg::BASE_MASK_RESET;
            end
            for (int i = 0; i < csd_pkg::CTRL_REGS; i++) begin
                access_ctrl_q[i] <= csd_pkg::CTRL_RESET;
            end
            port_four_direction_ctrl_q <= 4'h0;
            port_four_function_ctrl_q <= 4'h0;
        end else if (wr_pend_q && hready_q) begin
            case (bus_addr_q)
                csd_pkg::ADDR_BASE_MASK0: region_base_mask_reg[0] <= hwdata;
                csd_pkg::ADDR_BASE_MASK1: region_base_mask_reg[1] <= hwdata;
                csd_pkg::ADDR_BASE_MASK2: region_base_mask_reg[2] <= hwdata;
                csd_pkg::ADDR_BASE_MASK3: region_base_mask_reg[3] <= hwdata;
                csd_pkg::ADDR_LOW_PAIR_CTRL: access_ctrl_q[0] <= hwdata[csd_pkg::CTRL_W-1:0];
                csd_pkg::ADDR_HIGH_PAIR_CTRL: access_ctrl_q[1] <= hwdata[csd_pkg::CTRL_W-1:0];
                csd_pkg::ADDR_OTHER_SPACE_CTRL: access_ctrl_q[2] <= hwdata[csd_pkg::CTRL_W-1:0];
                csd_pkg::ADDR_PORT_DIR: port_four_direction_ctrl_q <= hwdata[3:0];
                csd_pkg::ADDR_PORT_FUNC: port_four_function_ctrl_q <= hwdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        rdata_d = 32'h00000000;
        case (bus_addr_q)
            csd_pkg::ADDR_BASE_MASK0: rdata_d = region_base_mask_reg[0];
            csd_pkg::ADDR_BASE_MASK1: rdata_d = region_base_mask_reg[1];
            csd_pkg::ADDR_BASE_MASK2: rdata_d = region_base_mask_reg[2];
            csd_pkg::ADDR_BASE_MASK3: rdata_d = region_base_mask_reg[3];
            csd_pkg::ADDR_LOW_PAIR_CTRL: rdata_d = {25'h0, access_ctrl_q[0]};
            csd_pkg::ADDR_HIGH_PAIR_CTRL: rdata_d = {25'h0, access_ctrl_q[1]};
            csd_pkg::ADDR_OTHER_SPACE_CTRL: rdata_d = {25'h0, access_ctrl_q[2]};
            csd_pkg::ADDR_PORT_DIR: rdata_d = {28'h0000000, port_four_direction_ctrl_q};
            csd_pkg::ADDR_PORT_FUNC: rdata_d = {28'h0000000, port_four_function_ctrl_q};
            csd_pkg::ADDR_STATUS: begin
                rdata_d[csd_pkg::STAT_SEL_LSB +: 4] = ~sel_n_q;
                rdata_d[csd_pkg::STAT_BUSY_BIT] = state_q != csd_pkg::ST_IDLE;
                rdata_d[csd_pkg::STAT_WAIT_BIT] = wait_sync_q;
                rdata_d[csd_pkg::STAT_DMA_BIT] = from_dma_q;
            end
            default: rdata_d = 32'h00000000;
        endcase
    end

    assign hreadyout = hready_q;
    assign hrdata = hrdata_q;
    assign hresp = hresp_q;
    assign core_done = core_done_q;
    assign dma_done = dma_done_q;
    assign region_select_n = sel_n_q;
    assign bus_wide = wide_q;
    assign shared_port_pins_out = pin_out_q;
    assign shared_port_pins_oe = pin_oe_q;

    // Checks on the decoder, sequencer, pin routing, register reset and bus read timing.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_sel_onehot;
        $onehot0(~sel_n_q);
    endproperty
    a_sel_onehot: assert property (p_sel_onehot) else $error("more than one select active");

    property p_sel_only_access;
        (sel_n_q != 4'hf) |-> (state_q == csd_pkg::ST_ACCESS);
    endproperty
    a_sel_only_access: assert property (p_sel_only_access) else $error("select active outside a cycle");

    property p_sel_from_hit;
        take |=> (sel_n_q == ~$past(sel_d));
    endproperty
    a_sel_from_hit: assert property (p_sel_from_hit) else $error("select does not follow decode");

    property p_disabled_quiet;
        (take && !region_en[0]) |=> sel_n_q[0];
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled region selected");

    property p_min_cycle;
        take |=> (state_q == csd_pkg::ST_ACCESS) [*3];
    endproperty
    a_min_cycle: assert property (p_min_cycle) else $error("bus cycle shorter than basic length");

    property p_wait_extend;
        (state_q == csd_pkg::ST_ACCESS && cnt_q == 4'h0 && wait_sync_q) |=> (state_q == csd_pkg::ST_ACCESS);
    endproperty
    a_wait_extend: assert property (p_wait_extend) else $error("cycle ended under wait");

    property p_dummy_gap;
        (state_q == csd_pkg::ST_ACCESS && cnt_q == 4'h0 && !wait_sync_q && was_read_q && dummy_q == 2'h2)
            |=> (state_q == csd_pkg::ST_DUMMY) [*2] ##1 (state_q == csd_pkg::ST_IDLE);
    endproperty
    a_dummy_gap: assert property (p_dummy_gap) else $error("read recovery length wrong");

    property p_done_no_wait;
        (core_done_q || dma_done_q) |-> !$past(wait_sync_q);
    endproperty
    a_done_no_wait: assert property (p_done_no_wait) else $error("done while wait was asserted");

    property p_pin_routed;
        (pin_out_q != 4'hf) |-> ($past(port_four_direction_ctrl_q & port_four_function_ctrl_q) != 4'h0);
    endproperty
    a_pin_routed: assert property (p_pin_routed) else $error("select driven on unrouted pin");

    property p_reset_mask;
        $past(!rst_n) |-> (region_base_mask_reg[0] == csd_pkg::BASE_MASK_RESET);
    endproperty
    a_reset_mask: assert property (p_reset_mask) else $error("wrong base/mask reset value");

    property p_read_wait;
        (addr_phase && !hwrite && !rd_pend_q) |=> !hready_q ##1 hready_q;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read answer timing wrong");

    property p_cov_wait;
        (state_q == csd_pkg::ST_ACCESS && cnt_q == 4'h0 && wait_sync_q) ##[1:300] (core_done_q || dma_done_q);
    endproperty
    c_cov_wait: cover property (p_cov_wait);

    property p_cov_dummy;
        state_q == csd_pkg::ST_DUMMY;
    endproperty
    c_cov_dummy: cover property (p_cov_dummy);

    property p_cov_dma;
        from_dma_q && !sel_n_q[0];
    endproperty
    c_cov_dma: cover property (p_cov_dma);

    property p_cov_region3;
        !sel_n_q[3];
    endproperty
    c_cov_region3: cover property (p_cov_region3);

endmodule : csd_chip_select

// ==== rtl/csd_pkg.sv ====
// Package with the register map, field layouts, reset values and states of the chip-select decoder.
package csd_pkg;

    localparam int REGIONS = 4;
    localparam int CTRL_REGS = 3;

    // Register byte addresses on the AHB-Lite bus.
    localparam logic [31:0] ADDR_BASE_MASK0 = 32'hffffe400;
    localparam logic [31:0] ADDR_BASE_MASK1 = 32'hffffe404;
    localparam logic [31:0] ADDR_BASE_MASK2 = 32'hffffe408;
    localparam logic [31:0] ADDR_BASE_MASK3 = 32'hffffe40c;
    localparam logic [31:0] ADDR_LOW_PAIR_CTRL = 32'hffffe480;
    localparam logic [31:0] ADDR_HIGH_PAIR_CTRL = 32'hffffe484;
    localparam logic [31:0] ADDR_OTHER_SPACE_CTRL = 32'hffffe488;
    localparam logic [31:0] ADDR_PORT_DIR = 32'hffffe490;
    localparam logic [31:0] ADDR_PORT_FUNC = 32'hffffe494;
    localparam logic [31:0] ADDR_STATUS = 32'hffffe498;

    // Base/mask register layout.
    localparam int BASE_MSB = 31;
    localparam int BASE_LSB = 16;
    localparam int MASK_MSB = 15;
    localparam logic [31:0] BASE_MASK_RESET = 32'h000003ff;
    localparam logic [31:0] BASE_MASK_WMASK = 32'hffffffff;

    // Mask bit 0 acts on A14 for regions 0 and 1 and on A15 for regions 2 and 3.
    localparam logic [4:0] REGION_SHIFT [REGIONS] = '{5'd14, 5'd14, 5'd15, 5'd15};
    localparam logic [31:0] REGION_LOW_BITS [REGIONS] = '{32'h00003fff, 32'h00003fff, 32'h00007fff, 32'h00007fff};

    // Access control register layout.
    localparam int CTRL_W = 7;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_WIDE_BIT = 1;
    localparam int CTRL_WAIT_LSB = 2;
    localparam int CTRL_WAIT_MSB = 4;
    localparam int CTRL_DUMMY_LSB = 5;
    localparam int CTRL_DUMMY_MSB = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
    localparam int CTRL_LOW_PAIR = 0;
    localparam int CTRL_HIGH_PAIR = 1;
    localparam int CTRL_OTHER = 2;

    // Status register layout.
    localparam int STAT_SEL_LSB = 0;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_WAIT_BIT = 5;
    localparam int STAT_DMA_BIT = 6;

    // Bus cycle timing in system clocks.
    localparam logic [3:0] BASE_CYCLES = 4'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_DUMMY} csd_state_t;

endpackage : csd_pkg

// ==== tb/csd_ext_device.sv ====
// Behavioural model of an external memory that can hold the wait pin low.
`timescale 1ns/1ps

module csd_ext_device (
    // Clock.
    input wire logic clk,
    // Bus side.
    input wire logic [3:0] region_select_n,
    input wire logic [7:0] stall_cycles,
    output logic ext_wait_n
);
    logic [7:0] left_q = 8'h00;
    logic idle_q = 1'b1;
    logic wait_q = 1'b1;

    // The model drives the pin from wait_q, so a released wait line reads high.
    assign ext_wait_n = wait_q;

    always @(posedge clk) begin
        idle_q <= &region_select_n;
        if (idle_q && !(&region_select_n) && stall_cycles != 8'h00) begin
            left_q <= stall_cycles;
            wait_q <= 1'b0;
        end else if (left_q > 8'h01) begin
            left_q <= left_q - 8'h01;
        end else begin
            left_q <= 8'h00;
            wait_q <= 1'b1;
        end
    end
endmodule : csd_ext_device

// ==== tb/test_chip_select_range_decoder.sv ====
// Self-checking testbench of the chip-select decoder.
`timescale 1ns/1ps

module test_chip_select_range_decoder;
    typedef struct {logic [1:0] r; logic [31:0] bm; logic [6:0] ctrl; logic [31:0] a; logic [3:0] sel; int w;} csd_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = csd_pkg::HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic core_req = 1'b0;
    logic [31:0] core_addr = 32'h0;
    logic core_wr = 1'b1;
    logic dma_req = 1'b0;
    logic [31:0] dma_addr = 32'h0;
    logic [7:0] stall = 8'h00;
    logic hreadyout, hresp, core_done, dma_done, ext_wait_n, bus_wide;
    logic [31:0] hrdata, rd;
    logic [3:0] region_select_n, pins_out, pins_oe, sel, pins;
    int num_errors = 0;
    int checked = 0;
    int n;
    csd_row_t rows [7] = '{
        '{2'd0, 32'h00100000, 7'h01, 32'h00103ffc, 4'he, 0},
        '{2'd0, 32'h00100000, 7'h01, 32'h00104000, 4'hf, 0},
        '{2'd1, 32'h00200001, 7'h0d, 32'h00204000, 4'hd, 3},
        '{2'd2, 32'h00300001, 7'h01, 32'h0030c000, 4'hb, 0},
        '{2'd3, 32'h00400000, 7'h05, 32'h00400000, 4'h7, 1},
        '{2'd3, 32'h00400000, 7'h05, 32'h003fc000, 4'hf, 0},
        '{2'd0, 32'h00100000, 7'h01, 32'h00100000, 4'he, 0}
    };

    always #20 clk = ~clk;

    csd_chip_select dut (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .core_req(core_req), .core_addr(core_addr), .core_write(core_wr),
        .core_done(core_done), .dma_req(dma_req), .dma_addr(dma_addr), .dma_write(1'b1),
        .dma_done(dma_done), .ext_wait_n(ext_wait_n), .region_select_n(region_select_n),
        .bus_wide(bus_wide), .shared_port_pins_out(pins_out), .shared_port_pins_oe(pins_oe)
    );

    csd_ext_device ext (.clk(clk), .region_select_n(region_select_n), .stall_cycles(stall),
        .ext_wait_n(ext_wait_n));

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task print_verdict();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // Outputs are registered, so the level at the falling edge is the one the next rising edge samples.
    task wait_ready();
        do @(negedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge clk);
    endtask : wait_ready

    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
    endtask : ahb

    // The request is held until done is seen and dropped at the next rising edge.
    task access(input logic use_dma, input logic [31:0] a);
        n = 0;
        if (use_dma) begin
            dma_addr <= a;
            dma_req <= 1'b1;
        end else begin
            core_addr <= a;
            core_req <= 1'b1;
        end
        do begin
            @(posedge clk);
            n++;
            @(negedge clk);
            if (n == 1) sel = region_select_n;
            if (n == 2) pins = pins_out;
        end while (core_done !== 1'b1 && dma_done !== 1'b1 && n < 60);
        check("done seen", 32'h1, 32'(n < 60));
        @(posedge clk);
        core_req <= 1'b0;
        dma_req <= 1'b0;
        repeat (16) @(posedge clk);
    endtask : access

    initial begin
        #(40 * 30000);
        num_errors++;
        $display("watchdog expired");
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            ahb(1'b0, csd_pkg::ADDR_BASE_MASK0 + 32'(4 * i), 32'h0);
            check("base mask reset", csd_pkg::BASE_MASK_RESET, rd);
            ahb(1'b1, csd_pkg::ADDR_BASE_MASK0 + 32'(4 * i), 32'hff000000);
        end
        ahb(1'b0, csd_pkg::ADDR_LOW_PAIR_CTRL, 32'h0);
        check("ctrl reset", 32'h0, rd);
        ahb(1'b0, 32'hffffe4f0, 32'h0);
        check("unmapped read", 32'h0, rd);
        foreach (rows[i]) begin
            // Row bases are physical addresses and leave the upper mask bits clear.
            ahb(1'b1, csd_pkg::ADDR_BASE_MASK0 + 32'(4 * rows[i].r), rows[i].bm);
            ahb(1'b0, csd_pkg::ADDR_BASE_MASK0 + 32'(4 * rows[i].r), 32'h0);
            check("base mask readback", rows[i].bm, rd);
            check("okay response", 32'h0, 32'(hresp));
            ahb(1'b1, rows[i].r < 2 ? csd_pkg::ADDR_LOW_PAIR_CTRL : csd_pkg::ADDR_HIGH_PAIR_CTRL, 32'(rows[i].ctrl));
            access(1'b0, rows[i].a);
            check("select", 32'(rows[i].sel), 32'(sel));
            check("cycle length", 32'(4 + rows[i].w), 32'(n));
            check("unrouted pins", 32'hf, 32'(pins));
        end
        // Region 1 overlaps region 0; the lower number must win.
        ahb(1'b1, csd_pkg::ADDR_BASE_MASK1, 32'h00100000);
        access(1'b0, 32'h00100000);
        check("overlap select", 32'he, 32'(sel));
        access(1'b1, 32'h00100000);
        check("dma select", 32'he, 32'(sel));
        ahb(1'b1, csd_pkg::ADDR_LOW_PAIR_CTRL, 32'h0);
        access(1'b0, 32'h00100000);
        check("disabled select", 32'hf, 32'(sel));
        ahb(1'b1, csd_pkg::ADDR_LOW_PAIR_CTRL, 32'h0d);
        ahb(1'b1, csd_pkg::ADDR_PORT_DIR, 32'h1);
        ahb(1'b1, csd_pkg::ADDR_PORT_FUNC, 32'h1);
        stall <= 8'h08;
        access(1'b0, 32'h00100000);
        check("routed pins", 32'he, 32'(pins));
        check("pin enable", 32'h1, 32'(pins_oe));
        check("stretched cycle", 32'h1, 32'(n > 7));
        check("narrow bus", 32'h0, 32'(bus_wide));
        stall <= 8'h00;
        // A read with two recovery cycles on a wide bus; the sequencer's own check times the recovery.
        ahb(1'b1, csd_pkg::ADDR_LOW_PAIR_CTRL, 32'h43);
        core_wr <= 1'b0;
        access(1'b0, 32'h00100000);
        check("read cycle length", 32'h4, 32'(n));
        check("wide bus", 32'h1, 32'(bus_wide));
        core_wr <= 1'b1;
        // A reset in mid-run returns selects, pins and registers to their reset state.
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("reset selects", 32'hf, 32'(region_select_n));
        check("reset pin enable", 32'h0, 32'(pins_oe));
        @(posedge clk);
        ahb(1'b0, csd_pkg::ADDR_BASE_MASK0, 32'h0);
        check("base mask after reset", csd_pkg::BASE_MASK_RESET, rd);
        print_verdict();
    end
endmodule : test_chip_select_range_decoder
